// file: verilog/cmr_regs.svh
// Register map, field positions, reset values and bus timing counts
// for the mode-request control block. Included by the recessive counter, top and bench.
// Contract
// - Sleep is entered only when not receiving and all transmit buffers are empty
// - Writing 1 to sleep_request bit 1 requests sleep; 0 keeps running
// - sleep_request cannot be set while wake_interrupt_flag is set
// - Sleep lasts until CPU clears request, or wake activity clears it
// - CPU clear of sleep_request ignored until request and acknowledge both 1
// - Setting init_request bit 0 aborts traffic and drops bus synchronisation
// - Entry into initialisation is shown by init_acknowledge
// - Initialisation entry resets control zero, flags, enables, abort and select registers; code keeps wake_enable and sleep_request
// - Transmitter and receiver status bits keep their values in initialisation
// - Control one, timing and acceptance registers writable only in initialisation
// - After init exit, resync on 11 recessive bits, or 128 times that when bus-off
// - CPU clear of init_request ignored until request and acknowledge both 1
// - Transmit pin forced recessive at once on initialisation request
// - Transmit pin forced recessive at once on stop, or wait with stop_in_wait
// - received_frame_flag is set only in normal mode
// - Clearing sleep_request also clears sleep_acknowledge
// - Initialisation is active only while request and acknowledge are both 1
// - Transmit pin low is dominant, high is recessive
`ifndef CMR_REGS_SVH
`define CMR_REGS_SVH
// Word indices; byte address is four times the index
`define CMR_IX_CTL0 6'h00
`define CMR_IX_CTL1 6'h01
`define CMR_IX_BTR0 6'h02
`define CMR_IX_BTR1 6'h03
`define CMR_IX_IDAC 6'h04
`define CMR_IX_RFLG 6'h05
`define CMR_IX_RIER 6'h06
`define CMR_IX_TFLG 6'h07
`define CMR_IX_TIER 6'h08
`define CMR_IX_TARQ 6'h09
`define CMR_IX_TAAK 6'h0a
`define CMR_IX_TBSEL 6'h0b
`define CMR_IX_ACC 6'h10
// Field positions in bus_control_zero; the last is wake_interrupt_flag in the receive flags
`define CMR_B_RECEIVED_FRAME_FLAG 7
`define CMR_B_RXACT 6
`define CMR_B_STOP_IN_WAIT 5
`define CMR_B_SYNCH 4
`define CMR_B_TIME 3
`define CMR_B_WAKE_ENABLE 2
`define CMR_B_SLEEP_REQUEST 1
`define CMR_B_INIT_REQUEST 0
`define CMR_B_WAKE_INTERRUPT_FLAG 7
// Reset values
`define CMR_RST_CTL1 6'h00
`define CMR_RST_TFLG 3'h7
`define CMR_RST_BYTE 8'h00
// Resynchronisation counts
`define CMR_RECESSIVE_BITS 4'ha
`define CMR_BUSOFF_RUNS 7'h7f
`endif

// file: verilog/cmr_pkg.sv
// Types shared by the mode-request control block.
// Assumes a classic Wishbone master with 8-bit address and 32-bit data.
package cmr_pkg;
  typedef enum logic [1:0] {ST_INIT, ST_RESYNC, ST_RUN} cmr_state_e;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } cmr_wb_req_s;

  // Status from the rest of the controller, same clock
  typedef struct packed {
    logic       receiving;
    logic       tx_empty;
    logic       bus_off;
    logic       bit_tick;
    logic       frame_ok;
    logic       tx_bit;
    logic [2:0] tflg_set;
    logic [3:0] err_status;
  } cmr_core_s;
endpackage : cmr_pkg

// file: verilog/cmr_recessive_counter.sv
// Counts runs of recessive bits at the sample tick for bus resync.
// Assumes i_rx is already synchronised and i_tick is one cycle per bit.
`timescale 1ns/1ps
`include "cmr_regs.svh"
module cmr_recessive_counter (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  input  wire logic i_bus_off,
  input  wire logic i_tick,
  input  wire logic i_rx,
  output logic      o_done
);
  logic [3:0] bits;
  logic [6:0] runs;
  logic       run_end;

  assign run_end = i_tick && i_rx && (bits == `CMR_RECESSIVE_BITS);

  // Bit and run counters; a dominant bit restarts the current run
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bits   <= 4'h0;
      runs   <= 7'h00;
      o_done <= 1'b0;
    end
    else if (!i_run)
    begin
      bits   <= 4'h0;
      runs   <= 7'h00;
      o_done <= 1'b0;
    end
    else if (i_tick)
    begin
      bits   <= (!i_rx || run_end) ? 4'h0 : bits + 4'h1;
      runs   <= run_end ? runs + 7'h01 : runs;
      o_done <= run_end && (!i_bus_off || runs == `CMR_BUSOFF_RUNS);
    end
    else
    begin
      o_done <= 1'b0;
    end
  end
endmodule : cmr_recessive_counter

// file: verilog/cmr_top.sv
// Sleep and initialisation mode handshake with its register file.
// Assumes a classic Wishbone master and a bit-timing core on the same clock.
`timescale 1ns/1ps
`include "cmr_regs.svh"
module cmr_top (
  input  wire logic                 I_CORE_CLK,
  input  wire logic                 I_RESET,
  input  wire cmr_pkg::cmr_wb_req_s I_WB,
  input  wire cmr_pkg::cmr_core_s   I_CORE,
  input  wire logic                 I_RX,
  input  wire logic                 I_CPU_STOP,
  input  wire logic                 I_CPU_WAIT,
  output logic                      O_WB_ACK,
  output logic [31:0]               O_WB_DAT,
  output logic                      O_TX,
  output logic                      O_ABORT,
  output logic                      O_SYNCH,
  output logic                      O_INIT_ACTIVE,
  output logic                      O_SLEEP_ACTIVE
);
  cmr_pkg::cmr_state_e state;
  cmr_pkg::cmr_state_e next_state;
  logic       rx_meta;
  logic       rx_s;
  logic       received_frame_flag;
  logic       rxact;
  logic       stop_in_wait;
  logic       time_en;
  logic       wake_enable;
  logic       sleep_request;
  logic       init_request;
  logic       sleep_acknowledge;
  logic       init_acknowledge;
  logic [5:0] ctl1_cfg;
  logic [7:0] btr0;
  logic [7:0] btr1;
  logic [7:0] idac;
  logic [7:0] acc [0:15];
  logic       wake_interrupt_flag;
  logic [1:0] rflg_lo;
  logic [7:0] rier;
  logic [2:0] tflg;
  logic [7:0] tier;
  logic [2:0] tarq;
  logic [2:0] taak;
  logic [2:0] tbsel;
  logic       req;
  logic       wr;
  logic [5:0] ix;
  logic [7:0] wd;
  logic       init_active;
  logic       ctl0_open;
  logic       wake;
  logic       normal;
  logic       resync_done;
  logic       force_rec;
  logic [7:0] next_rd;

  // Bus decode: one request per ack, data on byte lane 0
  assign req = I_WB.cyc && I_WB.stb && !O_WB_ACK;
  assign wr  = req && I_WB.we && I_WB.sel[0];
  assign ix  = I_WB.adr[7:2];
  assign wd  = I_WB.dat[7:0];

  assign init_active = init_request && init_acknowledge;
  assign ctl0_open   = !init_request && !init_acknowledge;
  assign wake        = sleep_request && sleep_acknowledge && wake_enable && !rx_s;
  assign normal      = (state == cmr_pkg::ST_RUN) && !sleep_acknowledge;

  // Receive pin synchroniser; only the second stage is used
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
    end
    else
    begin
      rx_meta <= I_RX;
      rx_s    <= rx_meta;
    end
  end

  // Wishbone answer: ack one cycle after the strobe, dropped next cycle
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end
    else
    begin
      O_WB_ACK <= req;
      O_WB_DAT <= req ? {24'h00_0000, next_rd} : 32'h0000_0000;
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb
  begin
    next_rd = 8'h00;
    if (ix == `CMR_IX_CTL0)
      next_rd = {received_frame_flag, rxact, stop_in_wait, O_SYNCH, time_en, wake_enable, sleep_request, init_request};
    else if (ix == `CMR_IX_CTL1)
      next_rd = {ctl1_cfg, sleep_acknowledge, init_acknowledge};
    else if (ix == `CMR_IX_BTR0)
      next_rd = btr0;
    else if (ix == `CMR_IX_BTR1)
      next_rd = btr1;
    else if (ix == `CMR_IX_IDAC)
      next_rd = idac;
    else if (ix == `CMR_IX_RFLG)
      next_rd = {wake_interrupt_flag, rflg_lo[1], I_CORE.err_status, 1'b0, rflg_lo[0]};
    else if (ix == `CMR_IX_RIER)
      next_rd = rier;
    else if (ix == `CMR_IX_TFLG)
      next_rd = {5'h00, tflg};
    else if (ix == `CMR_IX_TIER)
      next_rd = tier;
    else if (ix == `CMR_IX_TARQ)
      next_rd = {5'h00, tarq};
    else if (ix == `CMR_IX_TAAK)
      next_rd = {5'h00, taak};
    else if (ix == `CMR_IX_TBSEL)
      next_rd = {5'h00, tbsel};
    else if (ix[5:4] == 2'h1)
      next_rd = acc[ix[3:0]];
  end

  // Init request: set any time, clear only once acknowledged
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      init_request <= 1'b1;
    else if (wr && ix == `CMR_IX_CTL0)
    begin
      if (wd[`CMR_B_INIT_REQUEST])
        init_request <= 1'b1;
      else if (init_active)
        init_request <= 1'b0;
    end
  end

  // Init acknowledge follows the request one cycle later
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      init_acknowledge <= 1'b1;
    else
      init_acknowledge <= init_request;
  end

  // Sleep request; wake activity clears it, a pending wake flag blocks it
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      sleep_request <= 1'b0;
    else if (wake)
      sleep_request <= 1'b0;
    else if (wr && ix == `CMR_IX_CTL0 && ctl0_open)
    begin
      if (wd[`CMR_B_SLEEP_REQUEST] && !wake_interrupt_flag)
        sleep_request <= 1'b1;
      else if (!wd[`CMR_B_SLEEP_REQUEST] && sleep_acknowledge)
        sleep_request <= 1'b0;
    end
  end

  // Sleep acknowledge waits for an idle bus
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      sleep_acknowledge <= 1'b0;
    else if (!sleep_request || wake)
      sleep_acknowledge <= 1'b0;
    else if (!I_CORE.receiving && I_CORE.tx_empty)
      sleep_acknowledge <= 1'b1;
  end

  // Remaining control zero bits, all but wake_enable held reset while init is active
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      received_frame_flag   <= 1'b0;
      rxact   <= 1'b0;
      stop_in_wait   <= 1'b0;
      time_en <= 1'b0;
      wake_enable    <= 1'b0;
    end
    else
    begin
      rxact <= I_CORE.receiving && !init_active;
      if (wr && ix == `CMR_IX_CTL0 && ctl0_open)
        wake_enable <= wd[`CMR_B_WAKE_ENABLE];
      if (init_active)
      begin
        received_frame_flag   <= 1'b0;
        stop_in_wait   <= 1'b0;
        time_en <= 1'b0;
      end
      else
      begin
        // Set beats a simultaneous write-one clear
        if (I_CORE.frame_ok && normal)
          received_frame_flag <= 1'b1;
        else if (wr && ix == `CMR_IX_CTL0 && wd[`CMR_B_RECEIVED_FRAME_FLAG])
          received_frame_flag <= 1'b0;
        if (wr && ix == `CMR_IX_CTL0 && ctl0_open)
        begin
          stop_in_wait   <= wd[`CMR_B_STOP_IN_WAIT];
          time_en <= wd[`CMR_B_TIME];
        end
      end
    end
  end

  // Configuration registers, writable only in initialisation
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      ctl1_cfg <= `CMR_RST_CTL1;
      btr0     <= `CMR_RST_BYTE;
      btr1     <= `CMR_RST_BYTE;
      idac     <= `CMR_RST_BYTE;
    end
    else if (wr && init_active)
    begin
      if (ix == `CMR_IX_CTL1)
        ctl1_cfg <= wd[7:2];
      else if (ix == `CMR_IX_BTR0)
        btr0 <= wd;
      else if (ix == `CMR_IX_BTR1)
        btr1 <= wd;
      else if (ix == `CMR_IX_IDAC)
        idac <= wd;
    end
  end

  // Acceptance code and mask bytes, one entry per word
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_acc
      always_ff @(posedge I_CORE_CLK or posedge I_RESET)
      begin
        if (I_RESET)
          acc[g] <= `CMR_RST_BYTE;
        else if (wr && init_active && ix == `CMR_IX_ACC + 6'(g))
          acc[g] <= wd;
      end
    end
  endgenerate

  // Flag and enable registers; status bits live outside and are untouched
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      wake_interrupt_flag   <= 1'b0;
      rflg_lo <= 2'h0;
      rier    <= `CMR_RST_BYTE;
      tflg    <= `CMR_RST_TFLG;
      tier    <= `CMR_RST_BYTE;
      tarq    <= 3'h0;
      taak    <= 3'h0;
      tbsel   <= 3'h0;
    end
    else if (init_active)
    begin
      wake_interrupt_flag   <= 1'b0;
      rflg_lo <= 2'h0;
      rier    <= `CMR_RST_BYTE;
      tflg    <= `CMR_RST_TFLG;
      tier    <= `CMR_RST_BYTE;
      tarq    <= 3'h0;
      taak    <= 3'h0;
      tbsel   <= 3'h0;
    end
    else
    begin
      if (wake)
        wake_interrupt_flag <= 1'b1;
      else if (wr && ix == `CMR_IX_RFLG && wd[`CMR_B_WAKE_INTERRUPT_FLAG])
        wake_interrupt_flag <= 1'b0;
      if (wr && ix == `CMR_IX_RFLG)
        rflg_lo <= rflg_lo & ~{wd[6], wd[0]};
      // Empty flags: hardware set wins over write-one clear
      tflg <= I_CORE.tflg_set | (tflg & ~((wr && ix == `CMR_IX_TFLG) ? wd[2:0] : 3'h0));
      taak <= taak | (tarq & I_CORE.tflg_set);
      if (wr && ix == `CMR_IX_TARQ)
        tarq <= wd[2:0] & ~I_CORE.tflg_set;
      else
        tarq <= tarq & ~I_CORE.tflg_set;
      if (wr && ix == `CMR_IX_RIER)
        rier <= wd;
      if (wr && ix == `CMR_IX_TIER)
        tier <= wd;
      if (wr && ix == `CMR_IX_TBSEL)
        tbsel <= wd[2:0];
    end
  end

  // Mode sequence: init, wait for recessive runs, then synchronised
  always_comb
  begin
    next_state = state;
    case (state)
      cmr_pkg::ST_INIT:
        if (!init_request && !init_acknowledge)
          next_state = cmr_pkg::ST_RESYNC;
      cmr_pkg::ST_RESYNC:
        if (resync_done)
          next_state = cmr_pkg::ST_RUN;
      default:
        next_state = state;
    endcase
    if (init_request)
      next_state = cmr_pkg::ST_INIT;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      state <= cmr_pkg::ST_INIT;
    else
      state <= next_state;
  end

  cmr_recessive_counter u_resync (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RESET),
    .i_run     (state == cmr_pkg::ST_RESYNC),
    .i_bus_off (I_CORE.bus_off),
    .i_tick    (I_CORE.bit_tick),
    .i_rx      (rx_s),
    .o_done    (resync_done)
  );

  // Forcing is taken from the write itself so the pin never lags the request
  assign force_rec = init_request || (wr && ix == `CMR_IX_CTL0 && wd[`CMR_B_INIT_REQUEST])
                  || I_CPU_STOP || (I_CPU_WAIT && stop_in_wait);

  // Pin and mode outputs, all registered
  always_ff @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      O_TX           <= 1'b1;
      O_ABORT        <= 1'b1;
      O_SYNCH        <= 1'b0;
      O_INIT_ACTIVE  <= 1'b0;
      O_SLEEP_ACTIVE <= 1'b0;
    end
    else
    begin
      O_TX           <= (force_rec || next_state != cmr_pkg::ST_RUN) ? 1'b1 : I_CORE.tx_bit;
      O_ABORT        <= force_rec;
      O_SYNCH        <= next_state == cmr_pkg::ST_RUN;
      O_INIT_ACTIVE  <= init_request && init_acknowledge;
      O_SLEEP_ACTIVE <= sleep_request && sleep_acknowledge;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  chk_sleep_acknowledge_idle: assert property ($rose(sleep_acknowledge) |-> $past(!I_CORE.receiving && I_CORE.tx_empty))
    else $error("sleep acknowledged on busy bus");
  chk_sleep_request_set: assert property (wr && ix == `CMR_IX_CTL0 && ctl0_open && wd[1] && !wake_interrupt_flag && !wake
    |=> sleep_request)
    else $error("sleep request not taken");
  chk_sleep_request_block: assert property (wr && ix == `CMR_IX_CTL0 && wd[1] && wake_interrupt_flag && !sleep_request |=> !sleep_request)
    else $error("sleep request set with wake flag");
  chk_wake_clear: assert property (wake |=> !sleep_request && !sleep_acknowledge && wake_interrupt_flag)
    else $error("wake did not end sleep");
  chk_sleep_request_hold: assert property (sleep_request && !sleep_acknowledge && !wake |=> sleep_request)
    else $error("sleep request cleared early");
  chk_init_ack: assert property ($rose(init_request) |=> init_acknowledge ##1 O_INIT_ACTIVE)
    else $error("init not acknowledged");
  chk_init_reset: assert property (init_active |=> !stop_in_wait && !time_en && rier == 8'h00 && tarq == 3'h0)
    else $error("init did not reset registers");
  chk_cfg_lock: assert property (wr && ix == `CMR_IX_BTR0 && !init_active |=> $stable(btr0))
    else $error("timing written outside init");
  chk_init_request_hold: assert property (init_request && !init_acknowledge |=> init_request)
    else $error("init request cleared early");
  chk_tx_init: assert property (wr && ix == `CMR_IX_CTL0 && wd[0] |=> O_TX && O_ABORT)
    else $error("pin not recessive on init");
  chk_tx_stop: assert property (I_CPU_STOP || (I_CPU_WAIT && stop_in_wait) |=> O_TX)
    else $error("pin not recessive in stop");
  chk_frame_normal: assert property ($rose(received_frame_flag) |-> $past(normal))
    else $error("frame flag outside normal mode");
  chk_synch_path: assert property ($rose(O_SYNCH) |-> $past(state == cmr_pkg::ST_RESYNC && resync_done))
    else $error("synchronised without resync");

  cov_sleep: cover property ($rose(O_SLEEP_ACTIVE));
  cov_wake: cover property (wake);
  cov_resync: cover property ($rose(O_SYNCH));
endmodule : cmr_top

// file: test/cmr_bus_model.sv
// Far side of the block: bit engine status and the bus receive pin.
// Assumes one shared clock; a bit sample is offered on every cycle.
`timescale 1ns/1ps
module cmr_bus_model #(
  parameter logic [3:0] ERR_LEVEL = 4'h9
) (
  input  wire logic           i_busy,
  input  wire logic           i_bus_off,
  input  wire logic           i_rx_dom,
  input  wire logic           i_frame,
  output cmr_pkg::cmr_core_s  o_core,
  output logic                o_rx
);
  // Busy means a frame is arriving and a buffer still waits to go out
  // Sampling every cycle keeps the bus-off resync run short
  assign o_core = '{receiving: i_busy, tx_empty: !i_busy, bus_off: i_bus_off, bit_tick: 1'b1,
                    frame_ok: i_frame, tx_bit: 1'b0, tflg_set: 3'h0, err_status: ERR_LEVEL};
  // Pulled-up bus reads recessive once released; dominant is low
  assign o_rx = !i_rx_dom;
endmodule : cmr_bus_model

// file: test/test_can_mode_request_control.sv
// Self-checking bench for the sleep and initialisation handshake block.
// Assumes the bus model supplies core status and the receive pin.
`timescale 1ns/1ps
`include "cmr_regs.svh"
module test_can_mode_request_control;
  logic                 clk;
  logic                 rst;
  cmr_pkg::cmr_wb_req_s req;
  cmr_pkg::cmr_core_s   core;
  logic                 rx;
  logic                 cpu_stop;
  logic                 cpu_wait;
  logic                 busy;
  logic                 bus_off;
  logic                 rx_dom;
  logic                 frame;
  logic                 ack;
  logic [31:0]          dat;
  logic                 tx;
  logic                 abort;
  logic                 synch;
  logic                 init_act;
  logic                 sleep_act;
  logic [7:0]           rdata;
  int                   err_total;
  int                   total_checks;

  cmr_top DUT (.I_CORE_CLK(clk), .I_RESET(rst), .I_WB(req), .I_CORE(core), .I_RX(rx), .I_CPU_STOP(cpu_stop),
    .I_CPU_WAIT(cpu_wait), .O_WB_ACK(ack), .O_WB_DAT(dat), .O_TX(tx), .O_ABORT(abort), .O_SYNCH(synch),
    .O_INIT_ACTIVE(init_act), .O_SLEEP_ACTIVE(sleep_act));
  cmr_bus_model bus (.i_busy(busy), .i_bus_off(bus_off), .i_rx_dom(rx_dom), .i_frame(frame), .o_core(core),
    .o_rx(rx));

  // 10 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Classic single cycle; waits for ack without assuming its latency
  task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: {ix, 2'b00}, dat: {24'h0, d}};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdata = dat[7:0];
    req <= '0;
    chk({7'h0, ack}, 8'h01, "bus ack");
  endtask : wb

  task automatic rd_chk(input logic [5:0] ix, input logic [7:0] mask, input logic [7:0] exp, input string what);
    wb(1'b0, ix, 8'h00);
    chk(rdata & mask, exp, what);
  endtask : rd_chk

  // Short bounded wait: resync must land within two cycles of the expected edge
  task automatic wait_synch(input int lim);
    int n;
    n = 0;
    while (synch !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, synch}, 8'h01, "synch reached");
  endtask : wait_synch

  task automatic pulse_frame();
    @(posedge clk);
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_frame

  task automatic t_reset();
    rd_chk(`CMR_IX_CTL0, 8'hff, 8'h01, "ctl0 reset");
    rd_chk(`CMR_IX_CTL1, 8'hff, 8'h01, "ctl1 reset");
    rd_chk(6'h3f, 8'hff, 8'h00, "unmapped");
    chk({7'h0, init_act}, 8'h01, "init active");
    chk({7'h0, tx}, 8'h01, "tx recessive");
  endtask : t_reset

  task automatic t_config();
    wb(1'b1, `CMR_IX_BTR0, 8'h5a);
    rd_chk(`CMR_IX_BTR0, 8'hff, 8'h5a, "btr0 in init");
    wb(1'b1, `CMR_IX_RIER, 8'h0f);
    rd_chk(`CMR_IX_RIER, 8'hff, 8'h00, "rier held");
    wb(1'b1, `CMR_IX_CTL0, 8'h00);
    // Ten recessive bits must not be enough to synchronise
    repeat (13) @(posedge clk);
    chk({7'h0, synch}, 8'h00, "synch early");
    wait_synch(2);
    rd_chk(`CMR_IX_CTL1, 8'h01, 8'h00, "init ack cleared");
    wb(1'b1, `CMR_IX_BTR0, 8'ha5);
    rd_chk(`CMR_IX_BTR0, 8'hff, 8'h5a, "btr0 locked");
    pulse_frame();
    rd_chk(`CMR_IX_CTL0, 8'hff, 8'h90, "frame flag");
    chk({7'h0, tx}, 8'h00, "tx follows bit");
  endtask : t_config

  task automatic t_stop();
    chk({7'h0, abort}, 8'h00, "no forcing");
    cpu_wait <= 1'b1;
    repeat (2) @(posedge clk);
    chk({7'h0, abort}, 8'h00, "wait alone");
    wb(1'b1, `CMR_IX_CTL0, 8'h20);
    repeat (2) @(posedge clk);
    chk({6'h00, abort, tx}, 8'h03, "wait forcing");
    cpu_wait <= 1'b0;
    wb(1'b1, `CMR_IX_CTL0, 8'h00);
    cpu_stop <= 1'b1;
    repeat (2) @(posedge clk);
    chk({6'h00, abort, tx}, 8'h03, "stop forcing");
    cpu_stop <= 1'b0;
  endtask : t_stop

  task automatic t_sleep();
    busy <= 1'b1;
    wb(1'b1, `CMR_IX_CTL0, 8'h02);
    wb(1'b1, `CMR_IX_CTL0, 8'h00);
    rd_chk(`CMR_IX_CTL0, 8'h02, 8'h02, "early clear");
    rd_chk(`CMR_IX_CTL1, 8'h02, 8'h00, "no ack busy");
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h0, sleep_act}, 8'h01, "sleep entered");
    wb(1'b1, `CMR_IX_CTL0, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h0, sleep_act}, 8'h00, "sleep left");
    rd_chk(`CMR_IX_CTL1, 8'h02, 8'h00, "sleep ack clr");
  endtask : t_sleep

  task automatic t_wake();
    wb(1'b1, `CMR_IX_RIER, 8'h80);
    wb(1'b1, `CMR_IX_CTL0, 8'h06);
    repeat (3) @(posedge clk);
    chk({7'h0, sleep_act}, 8'h01, "sleep again");
    rx_dom <= 1'b1;
    repeat (6) @(posedge clk);
    rx_dom <= 1'b0;
    rd_chk(`CMR_IX_CTL0, 8'h06, 8'h04, "wake clears");
    rd_chk(`CMR_IX_RFLG, 8'h80, 8'h80, "wake flag");
    wb(1'b1, `CMR_IX_CTL0, 8'h06);
    rd_chk(`CMR_IX_CTL0, 8'h02, 8'h00, "set refused");
    wb(1'b1, `CMR_IX_RFLG, 8'h80);
    rd_chk(`CMR_IX_RFLG, 8'h80, 8'h00, "flag cleared");
  endtask : t_wake

  task automatic t_init();
    wb(1'b1, `CMR_IX_TIER, 8'h05);
    rd_chk(`CMR_IX_TIER, 8'hff, 8'h05, "tier written");
    // Park the node asleep first so the forced pin cannot cut a frame
    wb(1'b1, `CMR_IX_CTL0, 8'h06);
    repeat (3) @(posedge clk);
    chk({7'h0, sleep_act}, 8'h01, "asleep before init");
    wb(1'b1, `CMR_IX_CTL0, 8'h07);
    chk({6'h00, abort, tx}, 8'h03, "forced at ack");
    repeat (2) @(posedge clk);
    chk({6'h00, init_act, synch}, 8'h02, "init, unsynced");
    rd_chk(`CMR_IX_TIER, 8'hff, 8'h00, "tier reset");
    rd_chk(`CMR_IX_TFLG, 8'hff, 8'h07, "tflg reset");
    rd_chk(`CMR_IX_RFLG, 8'h3c, 8'h24, "status kept");
    pulse_frame();
    rd_chk(`CMR_IX_CTL0, 8'hff, 8'h07, "ctl0 in init");
  endtask : t_init

  task automatic t_busoff();
    bus_off <= 1'b1;
    wb(1'b1, `CMR_IX_CTL0, 8'h00);
    // One bit short of 128 runs must still leave the node unsynchronised
    repeat (1410) @(posedge clk);
    chk({7'h0, synch}, 8'h00, "bus-off early");
    wait_synch(2);
  endtask : t_busoff

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Watchdog: the whole sequence needs well under 3000 cycles
  initial
  begin
    repeat (6000) @(posedge clk);
    err_total++;
    close_out();
  end

  // Main sequence; software exits init before touching other bits
  initial
  begin
    err_total = 0;
    total_checks = 0;
    rst = 1'b1;
    req = '0;
    cpu_stop = 1'b0;
    cpu_wait = 1'b0;
    busy = 1'b0;
    bus_off = 1'b0;
    rx_dom = 1'b0;
    frame = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_stop();
    t_sleep();
    t_wake();
    t_init();
    t_busoff();
    close_out();
  end
endmodule : test_can_mode_request_control
